/* tb/csm_master_rx_tb.sv */
/*
 * Self-checking bench for the serial master receiver.
 * Assumes the slave model in csm_slave_model and the package csm_pkg.
 */
`timescale 1ns/100ps
module csm_master_rx_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    csm_pkg::csm_wb_req_t req = '0;
    logic ack, sck, sdi, irq, sck_q;
    logic [31:0] rdat, d;
    logic [3:0] ops = 4'h0;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C, 8'h20, 8'h24};
    logic [31:0] rv [8] = '{32'h200, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    int error_cnt = 0;
    int comparisons = 0;
    int irq_cnt = 0, cyc_n = 0, t_last = 0, hp = 0, w = 0, psc = 0;
    // Clock at 50 MHz
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    csm_master_rx csm_master_rx_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat), .serial_in_i(sdi),
        .serial_clock_o(sck), .channel_irq_o(irq));
    csm_slave_model csm_slave_model_inst (.clk_i(clk_i), .sck_i(sck), .pol_i(ops[1]),
        .lsb_i(ops[2]), .len7_i(ops[3]), .sdo_o(sdi));
    // Interrupt count and serial half period
    always @(negedge clk_i) begin
        cyc_n++;
        if (sck !== sck_q) begin
            hp = cyc_n - t_last;
            t_last = cyc_n;
        end
        sck_q = sck;
        if (irq === 1'b1) irq_cnt++;
    end
    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            error_cnt++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask : chk_cnt
    // One classic Wishbone cycle, result in d
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(negedge clk_i);
        if (n == 20) begin
            error_cnt++;
            wrap_up();
        end
        @(posedge clk_i);
        d = rdat;
        req <= '0;
    endtask : wb
    // Poll status until the frame and any pending word are done
    task automatic wait_done();
        int n;
        for (n = 0; n < 400; n++) begin
            wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
            if (d[2] === 1'b0 && d[4] === 1'b0 && d[1] === 1'b1) break;
        end
        if (n == 400) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_done
    // One received frame with interrupt, rate and status checks
    task automatic frame(input logic [7:0] div, input bit rd, input logic [31:0] st);
        int n;
        w = $urandom_range(0, 255);
        n = irq_cnt;
        csm_slave_model_inst.push(w);
        wb(1'b1, csm_pkg::ADR_DATA, {16'h0, div, 8'($urandom)});
        wait_done();
        chk_cnt(irq_cnt - n, 1);
        chk_cnt(hp, (1 << psc) * ((div[7:1] > 1 ? div[7:1] : 1) + 1));
        if (rd) begin
            wb(1'b0, csm_pkg::ADR_DATA, 32'h0);
            chk(d, {16'h0, div, ops[3] ? 8'(w & 32'h7F) : 8'(w)});
        end
        wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
        chk(d, st);
    endtask : frame
    initial begin
        int k;
        logic [7:0] div;
        w = $urandom(32'h42BBCF7F);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped offset reads zero
        for (k = 0; k < 8; k++) begin
            wb(1'b0, ra[k], 32'h0);
            chk(d, rv[k]);
        end
        wb(1'b1, csm_pkg::ADR_START, 32'h1);
        wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
        chk(d, 32'h8);
        // Clock enable low holds the bus answer back
        ce <= 1'b0;
        fork
            wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
            begin
                repeat (6) @(posedge clk_i);
                chk(32'(ack), 32'h0);
                ce <= 1'b1;
            end
        join
        chk(d, 32'h8);
        // Every phase, polarity, order and length
        for (k = 0; k < 16; k++) begin
            ops <= k[3:0];
            div = 8'($urandom_range(0, 7));
            psc = $urandom_range(0, 2);
            wb(1'b1, csm_pkg::ADR_OPSET, {28'h0, k[3:0]});
            wb(1'b1, csm_pkg::ADR_CKO, {31'h0, ~k[1]});
            wb(1'b1, csm_pkg::ADR_PRESC, 32'(psc));
            wb(1'b1, csm_pkg::ADR_SOE, 32'($urandom_range(0, 1)));
            frame(div, 1'b1, 32'h8);
        end
        // Second word lands on an unread one
        frame(div, 1'b0, 32'hA);
        frame(div, 1'b1, 32'h9);
        wb(1'b1, csm_pkg::ADR_FLAGCLR, 32'h1);
        wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
        chk(d, 32'h8);
        // Buffer-empty mode, pending word overwritten
        wb(1'b1, csm_pkg::ADR_MODE, 32'h1);
        k = irq_cnt;
        csm_slave_model_inst.push(8'h3C);
        csm_slave_model_inst.push(8'h5A);
        wb(1'b1, csm_pkg::ADR_DATA, {16'h0, div, 8'h00});
        wb(1'b1, csm_pkg::ADR_DATA, {16'h0, div, 8'h11});
        wb(1'b1, csm_pkg::ADR_DATA, {16'h0, div, 8'h22});
        // First frame still shifting, one word pending
        wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
        chk(d, 32'h1C);
        wait_done();
        chk_cnt(irq_cnt - k, 2);
        wb(1'b0, csm_pkg::ADR_DATA, 32'h0);
        chk(d, {16'h0, div, ops[3] ? 8'h5A : 8'h5A});
        // Second word completed on an unread first one
        wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
        chk(d, 32'h9);
        wb(1'b1, csm_pkg::ADR_FLAGCLR, 32'h1);
        wb(1'b1, csm_pkg::ADR_START, 32'h2);
        wb(1'b0, csm_pkg::ADR_STATUS, 32'h0);
        chk(d, 32'h0);
        wrap_up();
    end
endmodule : csm_master_rx_tb

/* tb/csm_slave_model.sv */
/*
 * Far-side slave model for the serial link: shifts queued words out.
 * Assumes the master's serial clock is a registered output on clk_i.
 */
`timescale 1ns/100ps
module csm_slave_model (
    // Clock and link
    input wire logic clk_i,
    input wire logic sck_i,
    // Frame format
    input wire logic pol_i,
    input wire logic lsb_i,
    input wire logic len7_i,
    // Serial data to the master
    output logic sdo_o
);
    int q[$];
    int idx = 0;
    logic prev = 1'b1;
    initial sdo_o = 1'b0;
    // Queue a word for a later frame
    task automatic push(input int w);
        q.push_back(w);
    endtask : push
    // Data changes on the edge opposite the sampling edge
    always @(posedge clk_i) begin
        prev <= sck_i;
        if (sck_i !== prev && sck_i === pol_i && q.size() > 0) begin
            sdo_o <= q[0][lsb_i ? idx : (len7_i ? 6 : 7) - idx];
            idx = idx + 1;
            if (idx == (len7_i ? 7 : 8)) begin
                idx = 0;
                void'(q.pop_front());
            end
        end else if (sck_i !== prev && sck_i !== pol_i && idx == 0) begin
            sdo_o <= ~sdo_o; // Line inverted between words: no stale value
        end
    end
endmodule : csm_slave_model

/* verilog/csm_master_rx.sv */
/*
 * Clocked serial master receiver channel with Wishbone classic slave.
 * Assumes serial_in_i synchronous to clk_i; ce_i freezes all state.
 */
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module csm_master_rx (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire csm_pkg::csm_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Serial link
    input wire logic serial_in_i,
    output logic serial_clock_o,
    // Interrupt pulse
    output logic channel_irq_o
);
    csm_pkg::csm_regs_t r_reg;
    csm_pkg::csm_regs_t r_next;
    logic acc;
    logic ovf_clr;
    logic done;
    logic edge_ev;
    logic [14:0] pmask;
    logic [6:0] halfm1;
    logic [3:0] last_edge;

    // Register offset match
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    // Received word aligned for length and order
    function automatic logic [7:0] fmt(input logic [7:0] sh, input logic lsb,
                                       input logic len7);
        if (!len7) begin
            fmt = sh;
        end else if (lsb) begin
            fmt = {1'b0, sh[7:1]};
        end else begin
            fmt = {1'b0, sh[6:0]};
        end
    endfunction : fmt

    // Next state of all registers
    always_comb begin
        r_next = r_reg;
        r_next.irq = 1'b0;
        acc = wb_req_i.cyc & wb_req_i.stb & ~r_reg.ack;
        ovf_clr = 1'b0;
        done = 1'b0;
        edge_ev = 1'b0;
        r_next.ack = acc;
        // Prescaler tick and half period length
        pmask = 15'((16'h0001 << r_reg.psc) - 16'h0001);
        halfm1 = (r_reg.div[7:1] == 7'h00) ? csm_pkg::HALF_MIN : r_reg.div[7:1];
        last_edge = r_reg.ops[csm_pkg::OPS_LEN7] ? csm_pkg::EDGES_7 : csm_pkg::EDGES_8;
        // Bus reads
        if (acc && !wb_req_i.we) begin
            r_next.rdat = 32'h0000_0000;
            if (hit(wb_req_i.adr, csm_pkg::ADR_DATA)) begin
                r_next.rdat = {16'h0000, r_reg.div, r_reg.rxdata};
                r_next.rxfull = 1'b0;
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_MODE)) begin
                r_next.rdat = {31'h0000_0000, r_reg.md};
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_OPSET)) begin
                r_next.rdat = {28'h000_0000, r_reg.ops};
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_STATUS)) begin
                r_next.rdat = {27'h000_0000, r_reg.txpend, r_reg.op_en,
                               r_reg.st == csm_pkg::CSM_SHIFT, r_reg.rxfull, r_reg.ovf};
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_PRESC)) begin
                r_next.rdat = {28'h000_0000, r_reg.psc};
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_SOE)) begin
                r_next.rdat = {31'h0000_0000, r_reg.soe};
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_CKO)) begin
                r_next.rdat = {31'h0000_0000, r_reg.cko};
            end
        end
        // Bus writes
        if (acc && wb_req_i.we) begin
            if (hit(wb_req_i.adr, csm_pkg::ADR_DATA)) begin
                if (wb_req_i.sel[1]) begin
                    r_next.div = wb_req_i.dat[15:8];
                end
                if (wb_req_i.sel[0] && r_reg.op_en) begin
                    if (r_reg.st == csm_pkg::CSM_IDLE) begin
                        r_next.st = csm_pkg::CSM_SHIFT;
                        r_next.pcnt = 15'h0000;
                        r_next.hcnt = 7'h00;
                        r_next.ecnt = 4'h0;
                        r_next.tog = 1'b0;
                        r_next.lead = r_reg.ops[csm_pkg::OPS_DAP];
                        r_next.sh = 8'h00;
                        r_next.irq = r_reg.md;
                    end else begin
                        r_next.txpend = 1'b1;
                    end
                end
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_MODE) && wb_req_i.sel[0]) begin
                r_next.md = wb_req_i.dat[0];
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_OPSET) && wb_req_i.sel[0]) begin
                r_next.ops = wb_req_i.dat[3:0];
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_START) && wb_req_i.sel[0]) begin
                if (wb_req_i.dat[csm_pkg::TRG_START]) begin
                    r_next.op_en = 1'b1;
                end
                if (wb_req_i.dat[csm_pkg::TRG_STOP]) begin
                    r_next.op_en = 1'b0;
                    r_next.st = csm_pkg::CSM_IDLE;
                    r_next.txpend = 1'b0;
                end
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_FLAGCLR) && wb_req_i.sel[0]) begin
                ovf_clr = wb_req_i.dat[csm_pkg::CLR_OVF];
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_PRESC) && wb_req_i.sel[0]) begin
                r_next.psc = wb_req_i.dat[3:0];
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_SOE) && wb_req_i.sel[0]) begin
                r_next.soe = wb_req_i.dat[0];
            end else if (hit(wb_req_i.adr, csm_pkg::ADR_CKO) && wb_req_i.sel[0]) begin
                r_next.cko = wb_req_i.dat[0];
            end
        end
        if (ovf_clr) begin
            r_next.ovf = 1'b0;
        end
        // Shift engine, clocked by prescaled half periods
        if (r_reg.st == csm_pkg::CSM_SHIFT && r_next.st == csm_pkg::CSM_SHIFT) begin
            r_next.pcnt = (r_reg.pcnt == pmask) ? 15'h0000 : r_reg.pcnt + 15'h0001;
            if (r_reg.pcnt == pmask) begin
                r_next.hcnt = (r_reg.hcnt == halfm1) ? 7'h00 : r_reg.hcnt + 7'h01;
                edge_ev = (r_reg.hcnt == halfm1);
            end
        end
        if (edge_ev) begin
            if (r_reg.lead) begin
                r_next.lead = 1'b0;
            end else begin
                r_next.tog = ~r_reg.tog;
                if (r_reg.ecnt[0]) begin
                    // Sample on second edge of each bit
                    r_next.sh = r_reg.ops[csm_pkg::OPS_LSB] ? {serial_in_i, r_reg.sh[7:1]}
                                : {r_reg.sh[6:0], serial_in_i};
                end
                if (r_reg.ecnt == last_edge) begin
                    done = 1'b1;
                    r_next.rxdata = fmt(r_next.sh, r_reg.ops[csm_pkg::OPS_LSB],
                                        r_reg.ops[csm_pkg::OPS_LEN7]);
                    if (r_next.rxfull) begin
                        r_next.ovf = 1'b1;
                    end
                    r_next.rxfull = 1'b1;
                    // Pending word includes a write landing on this very edge
                    r_next.irq = ~r_reg.md | r_next.txpend;
                    r_next.ecnt = 4'h0;
                    r_next.tog = 1'b0;
                    r_next.sh = 8'h00;
                    if (r_next.txpend) begin
                        r_next.txpend = 1'b0;
                        r_next.lead = r_reg.ops[csm_pkg::OPS_DAP];
                    end else begin
                        r_next.st = csm_pkg::CSM_IDLE;
                    end
                end else begin
                    r_next.ecnt = r_reg.ecnt + 4'h1;
                end
            end
        end
        // Serial clock level, idle or polarity applied
        if (r_next.st == csm_pkg::CSM_IDLE) begin
            r_next.sck = r_next.cko;
        end else begin
            r_next.sck = r_reg.ops[csm_pkg::OPS_CKP] ^ ~r_next.tog;
        end
    end

    // State register with clock enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '{st: csm_pkg::CSM_IDLE, div: csm_pkg::DIV_RST,
                       psc: csm_pkg::PSC_RST, cko: csm_pkg::CKO_RST,
                       sck: csm_pkg::CKO_RST, default: '0};
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o = r_reg.ack;
    assign wb_dat_o = r_reg.rdat;
    assign serial_clock_o = r_reg.sck;
    assign channel_irq_o = r_reg.irq;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property ((r_reg.ack && ce_i) |=> !r_reg.ack)
        else $error("ack held more than one cycle");
    a_start_enables: assert property (
        (ce_i && acc && wb_req_i.we && hit(wb_req_i.adr, csm_pkg::ADR_START)
         && wb_req_i.sel[0] && wb_req_i.dat[0] && !wb_req_i.dat[1]) |=> r_reg.op_en)
        else $error("start bit did not enable channel");
    a_dummy_start: assert property (
        (ce_i && acc && wb_req_i.we && hit(wb_req_i.adr, csm_pkg::ADR_DATA)
         && wb_req_i.sel[0] && r_reg.op_en && r_reg.st == csm_pkg::CSM_IDLE)
        |=> r_reg.st == csm_pkg::CSM_SHIFT)
        else $error("dummy write did not start transfer");
    a_pend_write: assert property (
        (ce_i && acc && wb_req_i.we && hit(wb_req_i.adr, csm_pkg::ADR_DATA)
         && wb_req_i.sel[0] && r_reg.st == csm_pkg::CSM_SHIFT && r_next.st != csm_pkg::CSM_IDLE
         && !done) |=> r_reg.txpend)
        else $error("write during shift not kept pending");
    a_ovf_sticky: assert property ((r_reg.ovf && !ovf_clr) |=> r_reg.ovf)
        else $error("overrun flag dropped without clear");
    a_ovf_cause: assert property ($rose(r_reg.ovf) |-> $past(done && r_reg.rxfull))
        else $error("overrun set without unread word");
    a_word_stored: assert property ((ce_i && done) |=> r_reg.rxfull)
        else $error("completed word not flagged");
    a_end_irq: assert property ((ce_i && done && !r_reg.md) |=> r_reg.irq)
        else $error("no transfer end interrupt");
    a_half_min: assert property (
        ($changed(r_reg.sck) && r_reg.st == csm_pkg::CSM_SHIFT
         && $past(r_reg.st) == csm_pkg::CSM_SHIFT) |=> $stable(r_reg.sck))
        else $error("serial clock faster than quarter rate");
    a_edge_toggle: assert property (
        (ce_i && edge_ev && !r_reg.lead && !done) |=> $changed(r_reg.sck))
        else $error("divided edge did not move clock");

    c_overrun: cover property ($rose(r_reg.ovf));
    c_cont_irq: cover property (r_reg.md && r_reg.irq && r_reg.st == csm_pkg::CSM_SHIFT);
    c_lead_phase: cover property (r_reg.lead ##1 !r_reg.lead);
    c_seven_bit: cover property (done && r_reg.ops[csm_pkg::OPS_LEN7]);
endmodule : csm_master_rx

/* verilog/csm_pkg.sv */
/*
 * Constants and types for the clocked serial master receiver.
 * Assumes a Wishbone classic bus with 32-bit data and byte addresses.
 */
package csm_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_DATA = 8'h00;
    localparam logic [7:0] ADR_MODE = 8'h04;
    localparam logic [7:0] ADR_OPSET = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0C;
    localparam logic [7:0] ADR_START = 8'h10;
    localparam logic [7:0] ADR_FLAGCLR = 8'h14;
    localparam logic [7:0] ADR_PRESC = 8'h18;
    localparam logic [7:0] ADR_SOE = 8'h1C;
    localparam logic [7:0] ADR_CKO = 8'h20;
    // Field positions
    localparam int OPS_DAP = 0;
    localparam int OPS_CKP = 1;
    localparam int OPS_LSB = 2;
    localparam int OPS_LEN7 = 3;
    localparam int STS_OVF = 0;
    localparam int STS_BFF = 1;
    localparam int STS_TSF = 2;
    localparam int STS_SE = 3;
    localparam int STS_PEND = 4;
    localparam int TRG_START = 0;
    localparam int TRG_STOP = 1;
    localparam int CLR_OVF = 0;
    // Reset values
    localparam logic [7:0] DIV_RST = 8'h02;
    localparam logic [3:0] PSC_RST = 4'h0;
    localparam logic CKO_RST = 1'b1;
    // Frame and divider limits
    localparam logic [3:0] EDGES_8 = 4'hF;
    localparam logic [3:0] EDGES_7 = 4'hD;
    localparam logic [6:0] HALF_MIN = 7'h01;

    typedef enum logic {CSM_IDLE, CSM_SHIFT} csm_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } csm_wb_req_t;

    typedef struct packed {
        csm_state_t st;
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic sck;
        logic op_en;
        logic ovf;
        logic rxfull;
        logic txpend;
        logic [7:0] rxdata;
        logic [7:0] div;
        logic md;
        logic [3:0] ops;
        logic [3:0] psc;
        logic soe;
        logic cko;
        logic [14:0] pcnt;
        logic [6:0] hcnt;
        logic [3:0] ecnt;
        logic tog;
        logic lead;
        logic [7:0] sh;
    } csm_regs_t;
endpackage : csm_pkg
